// ### csr_status_regs.sv
// Status word and control registers of the CPU core, with mode checks.
// Assumes the decode pipeline drives every input from core_clk logic.
`timescale 1ns/1ps
module csr_status_regs (
    input wire logic core_clk,
    input wire logic reset,
    input csr_pkg::csr_req_type ctl_req,
    output csr_pkg::csr_rsp_type ctl_rsp,
    input wire logic exc_enter,
    input wire logic [31:0] exc_pc,
    input wire logic exc_return,
    input wire logic repeat_setup_instr_valid,
    input wire logic [11:0] repeat_setup_instr_count,
    input wire logic [1:0] repeat_setup_instr_size,
    input wire logic cond_we,
    input wire logic cond_val,
    input wire logic div_we,
    input wire logic div_q_val,
    input wire logic div_m_val,
    input wire logic sat_we,
    input wire logic sat_val,
    input wire logic dsp_instr_valid,
    output logic dsp_illegal,
    input wire logic irq_req,
    input wire logic [3:0] irq_level,
    output logic irq_accept,
    input wire logic gpr_we,
    input wire logic [2:0] gpr_idx,
    input wire logic [31:0] gpr_wdata,
    output logic [31:0] gpr_rdata,
    input wire logic agu_valid,
    input wire logic agu_y_side,
    input wire logic [31:0] agu_addr,
    output logic [31:0] agu_addr_out,
    output logic agu_wrapped,
    output logic [31:0] status_word,
    output logic [31:0] saved_status_word,
    output logic [31:0] saved_return_pc,
    output logic [31:0] global_base_pointer,
    output logic [31:0] vector_table_base,
    output logic [31:0] loop_start_pointer,
    output logic [31:0] loop_finish_pointer,
    output logic [31:0] circular_bounds_reg
);
    logic privileged;
    logic dsp_on;
    logic bank_act;
    logic [31:0] alt_rdata;
    logic sel_sr;
    logic sel_priv_only;
    logic sel_dsp_only;
    logic req_illegal;
    logic req_ok_load;
    logic [31:0] load_mask;
    logic [31:0] rd_mux;
    logic [31:0] next_sr;

    // Mode decode from the status word as it stands now
    assign privileged = status_word[csr_pkg::PRIV_POS];
    assign dsp_on = status_word[csr_pkg::DSP_POS];
    // User mode always works in bank zero
    assign bank_act = privileged & status_word[csr_pkg::BANK_POS];

    // Which register class the request touches
    assign sel_sr = ctl_req.sel == csr_pkg::SEL_SR;
    assign sel_priv_only = ctl_req.sel inside {csr_pkg::SEL_SSR, csr_pkg::SEL_SPC,
        csr_pkg::SEL_VBR, csr_pkg::SEL_BANK};
    assign sel_dsp_only = ctl_req.sel inside {csr_pkg::SEL_RS, csr_pkg::SEL_RE,
        csr_pkg::SEL_MOD};

    // Access check; unknown select codes are refused as well
    assign req_illegal = ctl_req.valid && (
        (sel_sr && !privileged && !dsp_on)
        || (sel_priv_only && !privileged)
        || (sel_dsp_only && !dsp_on)
        || (ctl_req.sel > csr_pkg::SEL_BANK));
    assign req_ok_load = ctl_req.valid && ctl_req.load && !req_illegal;

    // Writable field mask of the status word in the current mode
    assign load_mask = privileged ? csr_pkg::SR_PRIV_MASK
        : csr_pkg::SR_USER_DSP_MASK;

    // Read data, taken whole in every mode that passes the check
    always_comb begin
        unique case (ctl_req.sel)
            csr_pkg::SEL_SR: rd_mux = status_word;
            csr_pkg::SEL_SSR: rd_mux = saved_status_word;
            csr_pkg::SEL_SPC: rd_mux = saved_return_pc;
            csr_pkg::SEL_GBR: rd_mux = global_base_pointer;
            csr_pkg::SEL_VBR: rd_mux = vector_table_base;
            csr_pkg::SEL_RS: rd_mux = loop_start_pointer;
            csr_pkg::SEL_RE: rd_mux = loop_finish_pointer;
            csr_pkg::SEL_MOD: rd_mux = circular_bounds_reg;
            csr_pkg::SEL_BANK: rd_mux = alt_rdata;
            default: rd_mux = csr_pkg::ZERO_WORD;
        endcase
    end

    // Next status word: return beats load, load beats setup and flag updates
    always_comb begin
        next_sr = status_word;
        if (exc_return) begin
            next_sr = saved_status_word;
        end else if (req_ok_load && sel_sr) begin
            next_sr = (status_word & ~load_mask) | (ctl_req.wdata & load_mask);
        end else begin
            if (repeat_setup_instr_valid) begin
                next_sr[csr_pkg::RC_LSB +: csr_pkg::RC_W] = repeat_setup_instr_count;
                next_sr[csr_pkg::RF_LSB +: csr_pkg::RF_W] = repeat_setup_instr_size;
            end
            if (cond_we) next_sr[csr_pkg::COND_POS] = cond_val;
            if (div_we) begin
                next_sr[csr_pkg::DIVQ_POS] = div_q_val;
                next_sr[csr_pkg::DIVM_POS] = div_m_val;
            end
            if (sat_we) next_sr[csr_pkg::SAT_POS] = sat_val;
        end
        // Reserved positions never hold a one, whatever was supplied
        next_sr = next_sr & ~csr_pkg::SR_RSV_MASK;
    end

    // Status word; divide and flag bits get zero as their undefined start
    always_ff @(posedge core_clk) begin
        if (reset) status_word <= csr_pkg::SR_RESET;
        else status_word <= next_sr;
    end

    // Exception save copies the word and pc before handler entry
    always_ff @(posedge core_clk) begin
        if (reset) begin
            saved_status_word <= csr_pkg::ZERO_WORD;
            saved_return_pc <= csr_pkg::ZERO_WORD;
        end else if (exc_enter) begin
            saved_status_word <= status_word;
            saved_return_pc <= exc_pc;
        end else if (req_ok_load) begin
            if (ctl_req.sel == csr_pkg::SEL_SSR) saved_status_word <= ctl_req.wdata;
            if (ctl_req.sel == csr_pkg::SEL_SPC) saved_return_pc <= ctl_req.wdata;
        end
    end

    // Base and loop registers loaded by control loads
    always_ff @(posedge core_clk) begin
        if (reset) begin
            global_base_pointer <= csr_pkg::ZERO_WORD;
            vector_table_base <= csr_pkg::VBR_RESET;
            loop_start_pointer <= csr_pkg::ZERO_WORD;
            loop_finish_pointer <= csr_pkg::ZERO_WORD;
            circular_bounds_reg <= csr_pkg::ZERO_WORD;
        end else if (req_ok_load) begin
            unique case (ctl_req.sel)
                csr_pkg::SEL_GBR: global_base_pointer <= ctl_req.wdata;
                csr_pkg::SEL_VBR: vector_table_base <= ctl_req.wdata;
                csr_pkg::SEL_RS: loop_start_pointer <= ctl_req.wdata;
                csr_pkg::SEL_RE: loop_finish_pointer <= ctl_req.wdata;
                csr_pkg::SEL_MOD: circular_bounds_reg <= ctl_req.wdata;
                default: ;
            endcase
        end
    end

    // Answer one cycle after the request; stores of refused requests read zero
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctl_rsp <= '0;
        end else begin
            ctl_rsp.valid <= ctl_req.valid;
            ctl_rsp.illegal <= req_illegal;
            ctl_rsp.rdata <= (ctl_req.valid && !ctl_req.load && !req_illegal)
                ? rd_mux : csr_pkg::ZERO_WORD;
        end
    end

    // DSP decode gate and interrupt acceptance against hold bit and level
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dsp_illegal <= 1'b0;
            irq_accept <= 1'b0;
        end else begin
            dsp_illegal <= dsp_instr_valid && !dsp_on;
            irq_accept <= irq_req && !status_word[csr_pkg::HOLD_POS]
                && (irq_level > status_word[csr_pkg::IMASK_LSB +: csr_pkg::IMASK_W]);
        end
    end

    // Banked general registers; alternate bank only through control access
    csr_bank_file #(
        .WIDTH(csr_pkg::DATA_W),
        .DEPTH(csr_pkg::BANK_DEPTH),
        .IW(csr_pkg::IDX_W)
    ) u_bank (
        .core_clk(core_clk),
        .bank_sel(bank_act),
        .act_we(gpr_we),
        .act_idx(gpr_idx),
        .act_wdata(gpr_wdata),
        .act_rdata(gpr_rdata),
        .alt_we(req_ok_load && ctl_req.sel == csr_pkg::SEL_BANK),
        .alt_idx(ctl_req.idx),
        .alt_wdata(ctl_req.wdata),
        .alt_rdata(alt_rdata)
    );

    // Modulo wrap for X/Y operand pointers
    csr_modulo_unit #(
        .AW(csr_pkg::DATA_W)
    ) u_modulo (
        .core_clk(core_clk),
        .reset(reset),
        .addr_valid(agu_valid),
        .y_side(agu_y_side),
        .addr_in(agu_addr),
        .x_circular_enable(status_word[csr_pkg::DMX_POS]),
        .y_circular_enable(status_word[csr_pkg::DMY_POS]),
        .circular_bounds_reg(circular_bounds_reg),
        .addr_out(agu_addr_out),
        .wrapped(agu_wrapped)
    );

    reset_image_a: assert property (@(posedge core_clk)
        $past(reset) && !reset |-> status_word == csr_pkg::SR_RESET)
        else $error("status word not at reset image");

    reserved_zero_a: assert property (@(posedge core_clk) disable iff (reset)
        (status_word & csr_pkg::SR_RSV_MASK) == csr_pkg::ZERO_WORD)
        else $error("reserved status bit is set");

    user_illegal_a: assert property (@(posedge core_clk) disable iff (reset)
        ctl_req.valid && sel_sr && !privileged && !dsp_on && !exc_return
        |=> ctl_rsp.valid && ctl_rsp.illegal && ctl_rsp.rdata == csr_pkg::ZERO_WORD
            && privileged == $past(privileged) && dsp_on == $past(dsp_on))
        else $error("user access to status word not refused");

    user_load_a: assert property (@(posedge core_clk) disable iff (reset)
        ctl_req.valid && ctl_req.load && sel_sr && !privileged && dsp_on && !exc_return
        |=> (status_word & ~csr_pkg::SR_USER_DSP_MASK)
            == ($past(status_word) & ~csr_pkg::SR_USER_DSP_MASK))
        else $error("user load changed a protected field");

    priv_load_a: assert property (@(posedge core_clk) disable iff (reset)
        ctl_req.valid && ctl_req.load && sel_sr && privileged && !exc_return
        |=> status_word == ($past(ctl_req.wdata) & csr_pkg::SR_PRIV_MASK))
        else $error("privileged load not taken whole");

    hold_mask_a: assert property (@(posedge core_clk) disable iff (reset)
        irq_req && status_word[csr_pkg::HOLD_POS] |=> !irq_accept)
        else $error("interrupt accepted while held");

    dsp_gate_a: assert property (@(posedge core_clk) disable iff (reset)
        dsp_instr_valid |=> dsp_illegal == !$past(dsp_on))
        else $error("DSP decode gate wrong");

    exc_save_a: assert property (@(posedge core_clk) disable iff (reset)
        exc_enter ##1 exc_return && !exc_enter
        |=> status_word == $past(saved_status_word) && saved_return_pc == $past(exc_pc, 2))
        else $error("exception save or restore wrong");

    repeat_setup_instr_a: assert property (@(posedge core_clk) disable iff (reset)
        repeat_setup_instr_valid && !exc_return && !(req_ok_load && sel_sr)
        |=> status_word[csr_pkg::RC_LSB +: csr_pkg::RC_W] == $past(repeat_setup_instr_count)
            && status_word[csr_pkg::RF_LSB +: csr_pkg::RF_W] == $past(repeat_setup_instr_size))
        else $error("repeat setup not stored");

    irq_accept_a: assert property (@(posedge core_clk) disable iff (reset)
        irq_req && !status_word[csr_pkg::HOLD_POS]
            && irq_level > status_word[csr_pkg::IMASK_LSB +: csr_pkg::IMASK_W]
        |=> irq_accept)
        else $error("unmasked interrupt not accepted");

    dsp_refuse_a: assert property (@(posedge core_clk) disable iff (reset)
        ctl_req.valid && sel_dsp_only && !dsp_on |=> ctl_rsp.valid && ctl_rsp.illegal)
        else $error("DSP control register reached with DSP off");

    exc_capture_a: assert property (@(posedge core_clk) disable iff (reset)
        exc_enter |=> saved_status_word == $past(status_word)
            && saved_return_pc == $past(exc_pc))
        else $error("exception entry did not save word and pc");
endmodule : csr_status_regs

// ### csr_pkg.sv
// Constants, selects and carrier types for the CPU status/control registers.
// Assumes a single core clock and a decode stage that presents one request per cycle.
// Operation
// - Privilege bit set means privileged mode, clear means user mode.
// - In privileged mode bank bit picks general register bank one or zero.
// - Inactive bank stays reachable through control load and store only.
// - Hold bit set masks interrupt requests; clear lets them be accepted.
// - Status word holds 12-bit repeat counter, set by repeat setup, resets zero.
// - DSP bit clear makes every DSP instruction an illegal instruction.
// - X and Y circular enables turn on modulo addressing per side; reset zero.
// - Status word holds 4-bit interrupt mask level resetting to all ones.
// - Carry/condition flag records compare outcome or carry, borrow, overflow.
// - Divide flags hold divide-step intermediate state; undefined after reset.
// - Reserved status bits read zero; software writes zero there.
// - Exception saves status word; return copies saved copy back.
// - Exception saves program counter as return address.
// - Global base pointer supplies base for global-base-indirect addressing.
// - Vector table base holds exception vector area base.
// - Loop start and finish pointers hold repeat loop bounds, DSP mode only.
// - Circular bounds: final address upper half, begin address lower half.
// - Modulo-enabled side address equal to final address reloads begin address.
// - User mode without DSP: any status word access raises invalid instruction.
// - Privileged DSP mode: status word fully readable and writable.
// - User DSP mode: status word store succeeds returning all fields.
// - User DSP mode load updates only repeat, size and circular fields.
// - Fields not writable in current mode keep their value on load.
// - Reset sets privilege, bank, hold bits, mask 1111, reserved zero.
// - Repeat size flags: 00 one, 01 two, 11 three, 10 four or more.
package csr_pkg;
    localparam int unsigned DATA_W = 32;
    // Status word field positions
    localparam int unsigned PRIV_POS = 30;
    localparam int unsigned BANK_POS = 29;
    localparam int unsigned HOLD_POS = 28;
    localparam int unsigned RC_LSB = 16;
    localparam int unsigned RC_W = 12;
    localparam int unsigned DSP_POS = 12;
    localparam int unsigned DMY_POS = 11;
    localparam int unsigned DMX_POS = 10;
    localparam int unsigned DIVM_POS = 9;
    localparam int unsigned DIVQ_POS = 8;
    localparam int unsigned IMASK_LSB = 4;
    localparam int unsigned IMASK_W = 4;
    localparam int unsigned RF_LSB = 2;
    localparam int unsigned RF_W = 2;
    localparam int unsigned SAT_POS = 1;
    localparam int unsigned COND_POS = 0;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned BANK_DEPTH = 8;
    localparam int unsigned IDX_W = 3;
    // Writable masks per mode and reset image
    localparam logic [31:0] SR_PRIV_MASK = 32'h7FFF1FFF;
    localparam logic [31:0] SR_USER_DSP_MASK = 32'h0FFF0C0C;
    localparam logic [31:0] SR_RSV_MASK = 32'h8000E000;
    localparam logic [31:0] SR_RESET = 32'h700000F0;
    localparam logic [31:0] VBR_RESET = 32'h00000000;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    localparam logic [3:0] IMASK_ALL = 4'hF;
    // Repeat body length codes
    localparam logic [1:0] RF_ONE = 2'h0;
    localparam logic [1:0] RF_TWO = 2'h1;
    localparam logic [1:0] RF_THREE = 2'h3;
    localparam logic [1:0] RF_MANY = 2'h2;

    typedef enum logic [3:0] {
        SEL_SR = 4'h0,
        SEL_SSR = 4'h1,
        SEL_SPC = 4'h2,
        SEL_GBR = 4'h3,
        SEL_VBR = 4'h4,
        SEL_RS = 4'h5,
        SEL_RE = 4'h6,
        SEL_MOD = 4'h7,
        SEL_BANK = 4'h8
    } csr_sel_type;

    typedef struct packed {
        logic valid;
        logic load;
        csr_sel_type sel;
        logic [2:0] idx;
        logic [31:0] wdata;
    } csr_req_type;

    typedef struct packed {
        logic valid;
        logic illegal;
        logic [31:0] rdata;
    } csr_rsp_type;
endpackage : csr_pkg

// ### csr_bank_file.sv
// Two banks of eight general registers, active and alternate port.
// Assumes the owner presents one write per port per cycle on core_clk.
`timescale 1ns/1ps
module csr_bank_file #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned IW = 3
) (
    input wire logic core_clk,
    input wire logic bank_sel,
    input wire logic act_we,
    input wire logic [IW-1:0] act_idx,
    input wire logic [WIDTH-1:0] act_wdata,
    output logic [WIDTH-1:0] act_rdata,
    input wire logic alt_we,
    input wire logic [IW-1:0] alt_idx,
    input wire logic [WIDTH-1:0] alt_wdata,
    output logic [WIDTH-1:0] alt_rdata
);
    logic [WIDTH-1:0] bank0 [DEPTH];
    logic [WIDTH-1:0] bank1 [DEPTH];

    // Alternate port always faces the bank not in use
    assign alt_rdata = bank_sel ? bank0[alt_idx] : bank1[alt_idx];

    // Contents are undefined from reset, so no reset here
    always_ff @(posedge core_clk) begin
        if (act_we && bank_sel) bank1[act_idx] <= act_wdata;
        if (act_we && !bank_sel) bank0[act_idx] <= act_wdata;
        if (alt_we && bank_sel) bank0[alt_idx] <= alt_wdata;
        if (alt_we && !bank_sel) bank1[alt_idx] <= alt_wdata;
        act_rdata <= bank_sel ? bank1[act_idx] : bank0[act_idx];
    end
endmodule : csr_bank_file

// ### csr_modulo_unit.sv
// Modulo wrap for X/Y operand address generation.
// Assumes the address arrives from the same-clock address generator.
`timescale 1ns/1ps
module csr_modulo_unit #(
    parameter int unsigned AW = 32
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic addr_valid,
    input wire logic y_side,
    input wire logic [AW-1:0] addr_in,
    input wire logic x_circular_enable,
    input wire logic y_circular_enable,
    input wire logic [31:0] circular_bounds_reg,
    output logic [AW-1:0] addr_out,
    output logic wrapped
);
    logic [csr_pkg::HALF_W-1:0] modulo_final_address;
    logic [csr_pkg::HALF_W-1:0] modulo_begin_address;
    logic side_on;
    logic hit;

    // Bounds halves; both enables together is reserved, so neither wraps
    assign modulo_final_address =
        circular_bounds_reg[csr_pkg::HALF_W +: csr_pkg::HALF_W];
    assign modulo_begin_address = circular_bounds_reg[csr_pkg::HALF_W-1:0];
    assign side_on = (x_circular_enable ^ y_circular_enable)
        && (y_side ? y_circular_enable : x_circular_enable);
    assign hit = addr_valid && side_on
        && (addr_in[csr_pkg::HALF_W-1:0] == modulo_final_address);

    // Replace the low half by the begin address on a match
    always_ff @(posedge core_clk) begin
        if (reset) begin
            addr_out <= '0;
            wrapped <= 1'b0;
        end else begin
            addr_out <= hit ? {addr_in[AW-1:csr_pkg::HALF_W], modulo_begin_address}
                : addr_in;
            wrapped <= hit;
        end
    end

    modulo_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
        hit |=> wrapped && addr_out[csr_pkg::HALF_W-1:0] == $past(modulo_begin_address))
        else $error("modulo wrap did not load begin address");
endmodule : csr_modulo_unit

// ### csr_decode_model.sv
// Model of the decode pipeline that issues control load and store requests.
// Assumes the status block registers its answer on the taking edge itself.
`timescale 1ns/1ps
module csr_decode_model (
    input wire logic core_clk,
    output csr_pkg::csr_req_type ctl_req,
    input csr_pkg::csr_rsp_type ctl_rsp
);
    initial ctl_req = '0;

    // One request held over its taking edge; answer read in the cycle after
    task automatic issue(input logic ld, input csr_pkg::csr_sel_type sel,
        input logic [31:0] wdata, output csr_pkg::csr_rsp_type rsp);
        logic [31:0] w;
        logic is_sr;
        w = wdata;
        is_sr = (sel == csr_pkg::SEL_SR) || (sel == csr_pkg::SEL_SSR);
        if (is_sr) w = w & ~csr_pkg::SR_RSV_MASK; // Reserved positions written as zero
        if (is_sr && w[11] && w[10]) w[11] = 1'b0; // Never both circular sides
        @(posedge core_clk);
        ctl_req <= '{valid: 1'b1, load: ld, sel: sel, idx: 3'h2, wdata: w};
        @(posedge core_clk);
        ctl_req.valid <= 1'b0;
        ctl_req.wdata <= ~w; // Stale data must not look valid
        #1;
        rsp = ctl_rsp;
    endtask : issue
endmodule : csr_decode_model

// ### cpu_status_control_regs_bench.sv
// Self-checking bench for the status and control register block.
// Assumes the decode model drives the control bus; side inputs driven here.
`timescale 1ns/1ps
module cpu_status_control_regs_bench;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    csr_pkg::csr_req_type ctl_req;
    csr_pkg::csr_rsp_type ctl_rsp, rsp;
    logic exc_enter = 1'b0, exc_return = 1'b0, repeat_setup_instr_valid = 1'b0, cond_we = 1'b0;
    logic cond_val = 1'b0, dsp_instr_valid = 1'b0, irq_req = 1'b0, gpr_we = 1'b0;
    logic div_we = 1'b0, div_q_val = 1'b0, div_m_val = 1'b0;
    logic agu_valid = 1'b0, agu_y_side = 1'b0, dsp_illegal, irq_accept, agu_wrapped;
    logic [31:0] exc_pc = 32'h0, gpr_wdata = 32'h0, agu_addr = 32'h0, gpr_rdata, agu_addr_out;
    logic [11:0] repeat_setup_instr_count = 12'h0;
    logic [1:0] repeat_setup_instr_size = 2'h0;
    logic [3:0] irq_level = 4'h0;
    logic [2:0] gpr_idx = 3'h0;
    logic [31:0] status_word, saved_status_word, saved_return_pc, global_base_pointer;
    logic [31:0] vector_table_base, loop_start_pointer, loop_finish_pointer, circular_bounds_reg;
    int bad_count = 0;
    int total_checks = 0;

    always #2.5 core_clk = ~core_clk;

    csr_decode_model i_csr_decode_model (.core_clk, .ctl_req, .ctl_rsp);

    // Saturation writer tied off; its bit carries no rule checked here
    csr_status_regs i_csr_status_regs (.core_clk, .reset, .ctl_req, .ctl_rsp, .exc_enter,
        .exc_pc, .exc_return, .repeat_setup_instr_valid, .repeat_setup_instr_count, .repeat_setup_instr_size, .cond_we, .cond_val,
        .div_we, .div_q_val, .div_m_val, .sat_we(1'b0), .sat_val(1'b0),
        .dsp_instr_valid, .dsp_illegal, .irq_req, .irq_level, .irq_accept, .gpr_we, .gpr_idx,
        .gpr_wdata, .gpr_rdata, .agu_valid, .agu_y_side, .agu_addr, .agu_addr_out,
        .agu_wrapped, .status_word, .saved_status_word, .saved_return_pc, .global_base_pointer,
        .vector_table_base, .loop_start_pointer, .loop_finish_pointer, .circular_bounds_reg);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic acc(input logic ld, input csr_pkg::csr_sel_type s, input logic [31:0] w);
        i_csr_decode_model.issue(ld, s, w, rsp);
    endtask : acc

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic t_reset_state;
        check(status_word, 32'h700000F0);
        check(vector_table_base, 32'h00000000);
        acc(1'b0, csr_pkg::SEL_SR, 32'h0);
        check(rsp.valid, 1'b1);
        check(rsp.rdata, 32'h700000F0);
        check(rsp.rdata & 32'h8000E000, 32'h0);
        $display("t_reset_state done");
    endtask : t_reset_state

    task automatic t_priv_regs;
        acc(1'b1, csr_pkg::SEL_GBR, 32'hC0DE0004);
        check(global_base_pointer, 32'hC0DE0004);
        acc(1'b1, csr_pkg::SEL_VBR, 32'h80000100);
        check(vector_table_base, 32'h80000100);
        acc(1'b1, csr_pkg::SEL_MOD, 32'h12340010);
        check(rsp.illegal, 1'b1);
        check(circular_bounds_reg, 32'h0);
        acc(1'b1, csr_pkg::SEL_SR, 32'h5ABC1A55);
        check(status_word, 32'h5ABC1A55);
        acc(1'b1, csr_pkg::SEL_RS, 32'h00A00010);
        check(loop_start_pointer, 32'h00A00010);
        acc(1'b1, csr_pkg::SEL_RE, 32'h00A00040);
        check(loop_finish_pointer, 32'h00A00040);
        acc(1'b1, csr_pkg::SEL_MOD, 32'h12340010);
        acc(1'b0, csr_pkg::SEL_MOD, 32'h0);
        check(rsp.rdata, 32'h12340010);
        @(posedge core_clk);
        gpr_we <= 1'b1;
        gpr_idx <= 3'h2;
        gpr_wdata <= 32'hAAAA0001;
        @(posedge core_clk);
        gpr_we <= 1'b0;
        acc(1'b1, csr_pkg::SEL_BANK, 32'hBBBB0002);
        @(posedge core_clk);
        #1;
        check(gpr_rdata, 32'hAAAA0001);
        acc(1'b0, csr_pkg::SEL_BANK, 32'h0);
        check(rsp.rdata, 32'hBBBB0002);
        $display("t_priv_regs done");
    endtask : t_priv_regs

    task automatic t_agu;
        @(posedge core_clk);
        agu_valid <= 1'b1;
        agu_y_side <= 1'b1;
        agu_addr <= 32'h00051234;
        irq_req <= 1'b1;
        irq_level <= 4'hF;
        @(posedge core_clk);
        agu_y_side <= 1'b0;
        irq_req <= 1'b0;
        #1;
        check(agu_wrapped, 1'b1);
        check(agu_addr_out, 32'h00050010);
        check(irq_accept, 1'b0);
        @(posedge core_clk);
        agu_valid <= 1'b0;
        #1;
        check(agu_wrapped, 1'b0);
        check(agu_addr_out, 32'h00051234);
        $display("t_agu done");
    endtask : t_agu

    task automatic t_exc_repeat_setup_instr;
        logic [1:0] codes [4];
        codes = '{csr_pkg::RF_ONE, csr_pkg::RF_TWO, csr_pkg::RF_THREE, csr_pkg::RF_MANY};
        @(posedge core_clk);
        exc_enter <= 1'b1;
        exc_pc <= 32'h0C001234;
        cond_we <= 1'b1;
        cond_val <= 1'b0;
        @(posedge core_clk);
        exc_enter <= 1'b0;
        cond_we <= 1'b0;
        exc_return <= 1'b1;
        #1;
        check(saved_status_word, 32'h5ABC1A55);
        check(saved_return_pc, 32'h0C001234);
        check(status_word, 32'h5ABC1A54);
        @(posedge core_clk);
        exc_return <= 1'b0;
        #1;
        check(status_word, 32'h5ABC1A55);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            repeat_setup_instr_valid <= 1'b1;
            repeat_setup_instr_count <= 12'h0F0 + 12'(i);
            repeat_setup_instr_size <= codes[i];
            cond_we <= 1'b1;
            cond_val <= i[0];
            div_we <= 1'b1;
            div_q_val <= i[0];
            div_m_val <= i[1];
            @(posedge core_clk);
            repeat_setup_instr_valid <= 1'b0;
            cond_we <= 1'b0;
            div_we <= 1'b0;
            #1;
            check(status_word[27:16], 12'h0F0 + 12'(i));
            check(status_word[3:2], codes[i]);
            check(status_word[0], i[0]);
            check(status_word[9:8], {i[1], i[0]});
        end
        $display("t_exc_repeat_setup_instr done");
    endtask : t_exc_repeat_setup_instr

    task automatic t_user_dsp;
        acc(1'b1, csr_pkg::SEL_SSR, 32'h00000030);
        acc(1'b1, csr_pkg::SEL_SR, 32'h00001000);
        check(status_word, 32'h00001000);
        acc(1'b1, csr_pkg::SEL_SR, 32'h75551AF8);
        check(status_word, 32'h05551808);
        acc(1'b0, csr_pkg::SEL_SR, 32'h0);
        check(rsp.illegal, 1'b0);
        check(rsp.rdata, 32'h05551808);
        acc(1'b0, csr_pkg::SEL_SSR, 32'h0);
        check(rsp.illegal, 1'b1);
        $display("t_user_dsp done");
    endtask : t_user_dsp

    task automatic t_user_plain;
        @(posedge core_clk);
        exc_return <= 1'b1;
        @(posedge core_clk);
        exc_return <= 1'b0;
        #1;
        check(status_word, 32'h00000030);
        acc(1'b0, csr_pkg::SEL_SR, 32'h0);
        check(rsp.illegal, 1'b1);
        check(rsp.rdata, 32'h0);
        acc(1'b1, csr_pkg::SEL_SR, 32'h70000000);
        check(rsp.illegal, 1'b1);
        check(status_word, 32'h00000030);
        @(posedge core_clk);
        dsp_instr_valid <= 1'b1;
        @(posedge core_clk);
        dsp_instr_valid <= 1'b0;
        #1;
        check(dsp_illegal, 1'b1);
        @(posedge core_clk);
        irq_req <= 1'b1;
        irq_level <= 4'h4;
        @(posedge core_clk);
        irq_level <= 4'h3;
        #1;
        check(irq_accept, 1'b1);
        @(posedge core_clk);
        irq_req <= 1'b0;
        #1;
        check(irq_accept, 1'b0);
        $display("t_user_plain done");
    endtask : t_user_plain

    // Watchdog: every wait is a fixed count, this only catches a stalled run
    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        t_reset_state();
        t_priv_regs();
        t_agu();
        t_exc_repeat_setup_instr();
        t_user_dsp();
        t_user_plain();
        test_done();
    end
endmodule : cpu_status_control_regs_bench
